/* verilog/adc_accum_pkg.sv */
package adc_accum_pkg;
  localparam int          ACC_W        = 16;
  localparam int          CONV_W       = 10;
  localparam int          LEFT_PAD     = ACC_W - CONV_W;
  localparam int          CNT_W        = 7;
  localparam logic [7:0]  PAGE_ACC     = 8'h00;
  localparam logic [7:0]  ADDR_CFG     = 8'hBA;
  localparam logic [7:0]  ADDR_RES_LO  = 8'hBD;
  localparam logic [7:0]  ADDR_RES_HI  = 8'hBE;
  localparam int          CFG_AE_BIT   = 6;
  localparam int          SJST_LSB     = 3;
  localparam int          RPT_LSB      = 0;
  localparam logic [2:0]  SJST_RESET   = 3'h0;
  localparam logic [2:0]  SJST_LEFT    = 3'h4;
  localparam logic [2:0]  RPT_RESET    = 3'h0;
  localparam logic [15:0] ACC_RESET    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  // Conversions per burst for each repeat code; reserved codes behave as one
  function automatic logic [CNT_W-1:0] burst_target(input logic [2:0] code);
    unique case (code)
      3'h1:    burst_target = 7'h04;
      3'h2:    burst_target = 7'h08;
      3'h3:    burst_target = 7'h10;
      3'h4:    burst_target = 7'h20;
      3'h5:    burst_target = 7'h40;
      default: burst_target = 7'h01;
    endcase
  endfunction
endpackage

/* verilog/acc_fmt_if.sv */
`timescale 1ns/100ps
interface acc_fmt_if;
  import adc_accum_pkg::*;
  logic [ACC_W-1:0] acc;
  logic [2:0]       sjst;
  logic [ACC_W-1:0] word;
  modport src (output acc, output sjst, input word);
  modport fmt (input acc, input sjst, output word);
endinterface

/* verilog/acc_formatter.sv */
`timescale 1ns/100ps
module acc_formatter
  import adc_accum_pkg::*;
(
  acc_fmt_if.fmt bus
);
  // Read-side view only; the stored accumulator is never touched here
  always_comb begin
    unique case (bus.sjst)
      3'h0:      bus.word = bus.acc;
      3'h1:      bus.word = bus.acc >> 1;
      3'h2:      bus.word = bus.acc >> 2;
      3'h3:      bus.word = bus.acc >> 3;
      SJST_LEFT: bus.word = {bus.acc[CONV_W-1:0], {LEFT_PAD{1'b0}}};
      default:   bus.word = bus.acc;
    endcase
  end
endmodule // acc_formatter

/* verilog/adc_accum.sv */
`timescale 1ns/100ps
module adc_accum
  import adc_accum_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  input  wire logic [7:0]        SFR_PAGE,
  input  wire logic [7:0]        SFR_ADDR,
  input  wire logic [7:0]        SFR_WDATA,
  input  wire logic              SFR_WR,
  input  wire logic              SFR_RD,
  output logic      [7:0]        SFR_RDATA,
  input  wire logic              BURST_EN,
  input  wire logic              CONV_VALID,
  input  wire logic [CONV_W-1:0] CONV_DATA,
  output logic                   DONE_SET,
  output logic      [ACC_W-1:0]  ACC_VALUE
);
  logic             ae_r, ae_nxt;
  logic [2:0]       sjst_r, sjst_nxt;
  logic [2:0]       rpt_r, rpt_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             done_r, done_nxt;
  logic [7:0]       rdata_r, rdata_nxt;
  logic             sel, wr_cfg, wr_hi, wr_lo, rd_cfg, rd_hi, rd_lo;
  logic [ACC_W-1:0] conv_ext;
  logic [CNT_W-1:0] cnt_inc;
  acc_fmt_if        fmt ();

  assign sel      = (SFR_PAGE == PAGE_ACC);
  assign wr_cfg   = SFR_WR && sel && (SFR_ADDR == ADDR_CFG);
  assign wr_hi    = SFR_WR && sel && (SFR_ADDR == ADDR_RES_HI);
  assign wr_lo    = SFR_WR && sel && (SFR_ADDR == ADDR_RES_LO);
  assign rd_cfg   = SFR_RD && sel && (SFR_ADDR == ADDR_CFG);
  assign rd_hi    = SFR_RD && sel && (SFR_ADDR == ADDR_RES_HI);
  assign rd_lo    = SFR_RD && sel && (SFR_ADDR == ADDR_RES_LO);
  assign conv_ext = {{LEFT_PAD{1'b0}}, CONV_DATA};
  assign cnt_inc  = cnt_r + 7'h01;
  assign fmt.acc  = acc_r;
  assign fmt.sjst = sjst_r;

  acc_formatter u_fmt (
    .bus (fmt)
  );

  always_comb begin
    ae_nxt   = ae_r;
    sjst_nxt = sjst_r;
    rpt_nxt  = rpt_r;
    if (wr_cfg) begin
      // Reserved top bit is not stored so it always reads back as zero
      ae_nxt   = SFR_WDATA[CFG_AE_BIT];
      sjst_nxt = SFR_WDATA[SJST_LSB +: 3];
      rpt_nxt  = SFR_WDATA[RPT_LSB +: 3];
    end
  end

  always_comb begin
    acc_nxt  = acc_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    // Leaving burst mode drops a half-finished count so the next burst starts clean
    if (!BURST_EN) begin
      cnt_nxt = 7'h00;
    end
    if (CONV_VALID) begin
      if (BURST_EN) begin
        // First conversion of a burst restarts the sum
        if (cnt_r == 7'h00) begin
          acc_nxt = conv_ext;
        end else begin
          acc_nxt = acc_r + conv_ext;
        end
        if (cnt_inc >= burst_target(rpt_r)) begin
          cnt_nxt  = 7'h00;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end else begin
        acc_nxt  = ae_r ? (acc_r + conv_ext) : conv_ext;
        done_nxt = 1'b1;
      end
    end
    // Software byte writes win over a conversion landing the same cycle
    if (wr_hi) begin
      acc_nxt[15:8] = SFR_WDATA;
    end
    if (wr_lo) begin
      acc_nxt[7:0] = SFR_WDATA;
    end
  end

  always_comb begin
    // Idle cycles return zero, so a late sample never sees a stale byte
    rdata_nxt = BYTE_ZERO;
    if (rd_cfg) begin
      rdata_nxt = {1'b0, 1'b0, sjst_r, rpt_r};
    end else if (rd_hi) begin
      rdata_nxt = fmt.word[15:8];
    end else if (rd_lo) begin
      rdata_nxt = fmt.word[7:0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ae_r    <= 1'b0;
      sjst_r  <= SJST_RESET;
      rpt_r   <= RPT_RESET;
    end else begin
      ae_r    <= ae_nxt;
      sjst_r  <= sjst_nxt;
      rpt_r   <= rpt_nxt;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_r   <= ACC_RESET;
      cnt_r   <= 7'h00;
      done_r  <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= BYTE_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign SFR_RDATA = rdata_r;
  assign DONE_SET  = done_r;
  assign ACC_VALUE = acc_r;

  logic quiet;
  assign quiet = !wr_hi && !wr_lo;

  load_single_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONV_VALID && !BURST_EN && !ae_r && quiet |=> acc_r == $past(conv_ext))
    else $error("single conversion did not replace the result");

  add_single_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONV_VALID && !BURST_EN && ae_r && quiet |=> acc_r == $past(acc_r) + $past(conv_ext))
    else $error("single conversion was not added");

  ae_reads_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_cfg && ae_r |=> !SFR_RDATA[CFG_AE_BIT])
    else $error("accumulate enable read back as one");

  fmt_keeps_acc_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_cfg && !CONV_VALID && quiet |=> $stable(acc_r))
    else $error("format change altered the accumulator");

  right_shift_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_lo && sjst_r < SJST_LEFT |=> SFR_RDATA == $past(acc_r >> sjst_r) % 256)
    else $error("right-justified low byte wrong");

  left_just_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_hi && sjst_r == SJST_LEFT |=> SFR_RDATA == $past(acc_r[9:2]))
    else $error("left-justified high byte wrong");

  burst_done_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONV_VALID && BURST_EN && cnt_inc < burst_target(rpt_r) |=> !DONE_SET)
    else $error("done raised before the burst finished");

  high_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_hi |=> acc_r[15:8] == $past(SFR_WDATA))
    else $error("high byte write not loaded");

  cfg_top_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_cfg |=> SFR_RDATA[7] == 1'b0)
    else $error("reserved configuration bit read as one");

  single_done_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONV_VALID && !BURST_EN |=> DONE_SET)
    else $error("single conversion did not raise done");

  burst_end_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONV_VALID && BURST_EN && cnt_inc >= burst_target(rpt_r) |=> DONE_SET)
    else $error("done missing at the end of a burst");

  burst_first_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONV_VALID && BURST_EN && cnt_r == 7'h00 && quiet |=> acc_r == $past(conv_ext))
    else $error("first burst conversion did not load");

  burst_add_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONV_VALID && BURST_EN && cnt_r != 7'h00 && quiet |=>
      acc_r == $past(acc_r) + $past(conv_ext))
    else $error("burst conversion was not added");

  acc_steady_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !CONV_VALID && quiet |=> $stable(acc_r))
    else $error("accumulator changed with no conversion or write");

  right_high_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_hi && sjst_r < SJST_LEFT |=> SFR_RDATA == $past(acc_r >> sjst_r) >> 8)
    else $error("right-justified high byte wrong");

  left_low_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_lo && sjst_r == SJST_LEFT |=> SFR_RDATA == {$past(acc_r[1:0]), 6'h00})
    else $error("left-justified low byte not zero filled");
endmodule // adc_accum

/* sim/adc_accum_tb.sv */
`timescale 1ns/100ps
module adc_accum_tb;
  import adc_accum_pkg::*;
  logic              MCLK, RST_N, SFR_WR, SFR_RD, BURST_EN, CONV_VALID, DONE_SET, rd_q;
  logic [7:0]        SFR_PAGE, SFR_ADDR, SFR_WDATA, SFR_RDATA;
  logic [CONV_W-1:0] CONV_DATA;
  logic [ACC_W-1:0]  ACC_VALUE, v, s;
  logic [7:0]        exp_rd[$];
  logic [ACC_W-1:0]  exp_acc[$];
  int                failures, tests_run, n;

  adc_accum u_dut (.MCLK(MCLK), .RST_N(RST_N), .SFR_PAGE(SFR_PAGE), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .BURST_EN(BURST_EN), .CONV_VALID(CONV_VALID), .CONV_DATA(CONV_DATA),
    .DONE_SET(DONE_SET), .ACC_VALUE(ACC_VALUE));

  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  // Every clocked task starts and ends 1 ns after a rising edge
  task automatic cyc();
    @(posedge MCLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc();
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    cyc();
    SFR_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    cyc();
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    cyc();
    SFR_RD = 1'b0;
  endtask
  task automatic cv(input logic [CONV_W-1:0] d);
    cyc();
    CONV_DATA = d;
    CONV_VALID = 1'b1;
    cyc();
    CONV_VALID = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] x);
    tests_run++;
    if (x !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, x);
    end
  endtask
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [15:0] fmt(input logic [15:0] a, input logic [2:0] c);
    return (c == SJST_LEFT) ? {a[CONV_W-1:0], {LEFT_PAD{1'b0}}} : a >> c;
  endfunction

  // Read data stands one cycle after the strobe; results checked mid-cycle
  always @(posedge MCLK) rd_q <= SFR_RD;
  always @(negedge MCLK) begin
    if (rd_q === 1'b1)
      chk("rdata", exp_rd.size() ? exp_rd.pop_front() : 8'hxx, SFR_RDATA);
    if (DONE_SET === 1'b1)
      chk("acc", exp_acc.size() ? exp_acc.pop_front() : 16'hxxxx, ACC_VALUE);
  end

  initial begin
    {SFR_WR, SFR_RD, BURST_EN, CONV_VALID} = 4'h0;
    SFR_PAGE = PAGE_ACC;
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    CONV_DATA = '0;
    RST_N = 1'b0;
    failures = 0;
    tests_run = 0;
    void'($urandom(32'h0000_ba4a));
    repeat (5) @(posedge MCLK);
    #1 RST_N = 1'b1;
    rd(ADDR_CFG, 8'h00);
    wr(ADDR_CFG, 8'hff);
    rd(ADDR_CFG, 8'h3f);
    wr(ADDR_CFG, 8'h00);
    repeat (2) begin
      v = 16'($urandom);
      exp_acc.push_back({6'h00, v[9:0]});
      cv(v[9:0]);
    end
    wr(ADDR_CFG, 8'h40);
    wr(ADDR_RES_HI, 8'h00);
    wr(ADDR_RES_LO, 8'h00);
    s = 16'h0000;
    repeat (3) begin
      v = 16'($urandom);
      s = s + {6'h00, v[9:0]};
      exp_acc.push_back(s);
      cv(v[9:0]);
    end
    v = 16'($urandom);
    wr(ADDR_RES_HI, v[15:8]);
    wr(ADDR_RES_LO, v[7:0]);
    for (n = 0; n < 5; n++) begin
      wr(ADDR_CFG, {2'b00, n[2:0], 3'b000});
      s = fmt(v, n[2:0]);
      rd(ADDR_RES_HI, s[15:8]);
      rd(ADDR_RES_LO, s[7:0]);
    end
    wr(ADDR_CFG, 8'h00);
    rd(ADDR_RES_HI, v[15:8]);
    rd(8'hbb, 8'h00);
    SFR_PAGE = 8'h01;
    rd(ADDR_RES_HI, 8'h00);
    SFR_PAGE = PAGE_ACC;
    BURST_EN = 1'b1;
    // First conversion of a burst loads, so the old word must not leak in
    for (n = 0; n < 6; n++) begin
      wr(ADDR_CFG, {5'h00, n[2:0]});
      s = 16'h0000;
      repeat (n ? 2 << n : 1) begin
        v = 16'($urandom);
        s = s + {6'h00, v[9:0]};
        cv(v[9:0]);
      end
      exp_acc.push_back(s);
    end
    wr(ADDR_CFG, 8'h00);
    BURST_EN = 1'b0;
    // Mid-run reset must clear the configuration, the enable and the sum
    wr(ADDR_CFG, 8'h60);
    rd(ADDR_CFG, 8'h20);
    cyc();
    RST_N = 1'b0;
    repeat (2) cyc();
    chk("reset acc", ACC_RESET, ACC_VALUE);
    RST_N = 1'b1;
    rd(ADDR_CFG, 8'h00);
    repeat (2) begin
      v = 16'($urandom);
      exp_acc.push_back({6'h00, v[9:0]});
      cv(v[9:0]);
    end
    repeat (4) cyc();
    if (exp_rd.size() || exp_acc.size()) failures++;
    results();
  end
endmodule // adc_accum_tb
